//--- sbp_pins_model.sv
// Behavioural model of the circuitry on the six port pins.
// Assumes pad enables and drive values come straight from the port block.
`timescale 1ns/100ps
module sbp_pins_model (
   input wire logic sys_clk_in,
   input wire logic [5:0] oe_in,
   input wire logic [5:0] drive_in,
   input wire logic [5:0] pullup_in,
   input wire logic [5:0] ext_en_in,
   input wire logic [5:0] ext_val_in,
   output logic [5:0] level_out
);
   logic [5:0] float_r = 6'h15;
   // A floating line keeps changing, so a stale level never passes for a match.
   always @(posedge sys_clk_in) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (oe_in[i]) begin
            level_out[i] = drive_in[i];
         end else if (ext_en_in[i]) begin
            level_out[i] = ext_val_in[i];
         end else if (pullup_in[i]) begin
            level_out[i] = 1'b1;
         end else begin
            level_out[i] = float_r[i];
         end
      end
   end
endmodule : sbp_pins_model

//--- sbp_pkg.sv
// Constants, selector codes and access kinds for the six-pin I/O port.
// Assumes one clock domain; every user of this package imports it whole.
package sbp_pkg;

   // ----------------------------------------------------------------
   // Widths and pin positions
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int PIN_W = 6;
   localparam int IDX_W = 3;
   localparam int INPUT_ONLY_IDX = 3;
   localparam int IOC_ENABLE_BIT = 3;
   localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;
   localparam logic [5:0] OSC_PIN_MASK = 6'h30;
   localparam logic [5:0] SHARED_FEATURE_MASK = 6'h0B;
   localparam logic [1:0] UNIMPL_BITS = 2'h0;

   // ----------------------------------------------------------------
   // Register selectors
   // ----------------------------------------------------------------
   localparam logic SEL_PORT_PIN_DATA = 1'b0;
   localparam logic SEL_PORT_PIN_DIRECTION = 1'b1;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [5:0] DIR_RESET = 6'h3F;
   localparam logic [5:0] LATCH_RESET = 6'h00;
   localparam logic [5:0] PIN_RESET = 6'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Access kinds, one instruction each
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_IDLE = 3'b000,
      OP_READ = 3'b001,
      OP_WRITE = 3'b010,
      OP_BIT_SET = 3'b011,
      OP_BIT_CLR = 3'b100
   } sbp_op_t;

endpackage : sbp_pkg

//--- sbp_port.sv
// Six-pin general purpose I/O port with direction control and change detection.
// Assumes the CPU issues one access per clock on reg_op_in and that the pin
// pads resolve pin_out/pin_oe_out/pullup_on_out into wire levels.
//
// Contract
// - Data register eight bits, six pins.
// - Data bits seven and six read zero.
// - Pin three input only, others configurable.
// - Direction one floats, zero drives latch.
// - Pin three direction always reads one.
// - Reset sets all direction bits.
// - Port read returns pin levels.
// - Output latch holds until rewritten.
// - Alternate-function pins read zero.
// - Pull-up and change on pins 0,1,3 together.
// - Change detection needs interrupt control bit 3.
// - External oscillator takes pins four, five.
// - Read-modify-write uses pins, writes whole latch.
// - Write at cycle end, read sampled first.
// - Analog pins read zero, still drive.
// - Open-drain pins pull low or float.
// - Change compares inputs with last read.
// - Access ends mismatch; mismatch keeps flag set.
// - Pull-ups off on outputs and after reset.
`timescale 1ns/100ps
module sbp_port (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire sbp_pkg::sbp_op_t reg_op_in,
   input wire logic reg_sel_in,
   input wire logic [sbp_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic [sbp_pkg::IDX_W-1:0] reg_bit_in,
   output logic [sbp_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic [sbp_pkg::PIN_W-1:0] alt_func_mask_in,
   input wire logic ext_osc_mode_in,
   input wire logic [sbp_pkg::PIN_W-1:0] analog_mask_in,
   input wire logic [sbp_pkg::PIN_W-1:0] open_drain_mask_in,
   input wire logic pullup_enable_in,
   input wire logic [7:0] interrupt_control_reg_in,
   input wire logic change_flag_clear_in,
   output logic port_change_flag_out,
   input wire logic [sbp_pkg::PIN_W-1:0] port_pins_five_to_zero_in,
   output logic [sbp_pkg::PIN_W-1:0] port_pins_five_to_zero_out,
   output logic [sbp_pkg::PIN_W-1:0] port_pins_five_to_zero_oe_out,
   output logic [sbp_pkg::PIN_W-1:0] pullup_on_out
);
   import sbp_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [5:0] bit_onehot(input logic [2:0] idx);
      logic [5:0] m;
      m = '0;
      if (idx < 3'd6) begin
         m[idx] = 1'b1;
      end
      return m;
   endfunction : bit_onehot

   function automatic logic [5:0] modify(input logic [5:0] base, input sbp_op_t op,
                                         input logic [5:0] wval, input logic [5:0] m);
      logic [5:0] r;
      r = base;
      case (op)
         OP_WRITE: begin
            r = wval;
         end
         OP_BIT_SET: begin
            r = base | m;
         end
         OP_BIT_CLR: begin
            r = base & ~m;
         end
         default: begin
            r = base;
         end
      endcase
      return r;
   endfunction : modify

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   // Pins are sampled two flops late, so a read right after a write may still
   // see the old level; software keeps an unrelated instruction between them.
   logic [5:0] pin_sync;

   sbp_sync #(
      .WIDTH(PIN_W)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .async_in(port_pins_five_to_zero_in),
      .sync_out(pin_sync)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [5:0] dir_r;
   logic [5:0] dir_nxt;
   logic [5:0] latch_r;
   logic [5:0] latch_nxt;
   logic [5:0] last_read_r;
   logic [5:0] last_read_nxt;
   logic [7:0] rdata_nxt;
   logic flag_nxt;
   logic [5:0] pin_out_nxt;
   logic [5:0] pin_oe_nxt;
   logic [5:0] pullup_nxt;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire is_access = (reg_op_in != OP_IDLE);
   wire is_write = is_access && (reg_op_in != OP_READ);
   wire sel_data = (reg_sel_in == SEL_PORT_PIN_DATA);
   wire port_access = is_access && sel_data;
   wire data_write = is_write && sel_data;
   wire dir_write = is_write && !sel_data;
   wire [5:0] osc_mask = ext_osc_mode_in ? OSC_PIN_MASK : 6'h00;
   wire [5:0] overridden = alt_func_mask_in | osc_mask;
   wire [5:0] read_blocked = overridden | analog_mask_in;
   wire [5:0] port_view = pin_sync & ~read_blocked;
   wire [5:0] dir_view = dir_r | INPUT_ONLY_MASK;
   wire [5:0] base_word = sel_data ? port_view : dir_view;
   wire [5:0] bit_mask = bit_onehot(reg_bit_in);
   // Bit operations start from pin levels, so input pins get their live level
   // copied into the latch; this is the price of a single port address.
   wire [5:0] new_word = modify(base_word, reg_op_in, reg_wdata_in[5:0], bit_mask);
   wire ioc_enable = interrupt_control_reg_in[IOC_ENABLE_BIT];
   wire [5:0] ioc_watch = SHARED_FEATURE_MASK & dir_view & {6{ioc_enable}};
   wire mismatch = |((pin_sync ^ last_read_r) & ioc_watch) && !port_access;
   wire [5:0] drive = ~dir_view & ~overridden;

   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   assign latch_nxt = data_write ? new_word : latch_r;
   assign dir_nxt = dir_write ? (new_word | INPUT_ONLY_MASK) : dir_r;
   assign last_read_nxt = port_access ? pin_sync : last_read_r;
   assign rdata_nxt = (reg_op_in == OP_READ) ? {UNIMPL_BITS, base_word} : reg_rdata_out;
   // Set wins over a software clear while the mismatch lasts.
   assign flag_nxt = mismatch | (port_change_flag_out & ~change_flag_clear_in);
   assign pin_out_nxt = latch_r & ~open_drain_mask_in;
   assign pin_oe_nxt = drive & ~(open_drain_mask_in & latch_r);
   assign pullup_nxt = SHARED_FEATURE_MASK & dir_view & ~overridden & {6{pullup_enable_in}};

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         dir_r <= DIR_RESET;
         latch_r <= LATCH_RESET;
         last_read_r <= PIN_RESET;
         reg_rdata_out <= RDATA_RESET;
         port_change_flag_out <= 1'b0;
      end else begin
         dir_r <= dir_nxt;
         latch_r <= latch_nxt;
         last_read_r <= last_read_nxt;
         reg_rdata_out <= rdata_nxt;
         port_change_flag_out <= flag_nxt;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         port_pins_five_to_zero_out <= PIN_RESET;
         port_pins_five_to_zero_oe_out <= PIN_RESET;
         pullup_on_out <= PIN_RESET;
      end else begin
         port_pins_five_to_zero_out <= pin_out_nxt;
         port_pins_five_to_zero_oe_out <= pin_oe_nxt;
         pullup_on_out <= pullup_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence port_read_s;
      (reg_op_in == OP_READ) && (reg_sel_in == SEL_PORT_PIN_DATA);
   endsequence

   sequence dir_read_s;
      (reg_op_in == OP_READ) && (reg_sel_in == SEL_PORT_PIN_DIRECTION);
   endsequence

   sequence quiet_data_s;
      !data_write [*3];
   endsequence

   sequence port_write_s;
      (reg_op_in == OP_WRITE) && (reg_sel_in == SEL_PORT_PIN_DATA);
   endsequence

   sequence dir_write_s;
      (reg_op_in == OP_WRITE) && (reg_sel_in == SEL_PORT_PIN_DIRECTION);
   endsequence

   upper_bits_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      reg_rdata_out[7:6] == 2'b00)
      else $error("Unimplemented port bits read non-zero.");

   read_pins_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      port_read_s |=> reg_rdata_out[5:0] == ($past(pin_sync) & ~$past(read_blocked)))
      else $error("Port read does not return the sampled pins.");

   alt_reads_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      port_read_s |=> (reg_rdata_out[5:0] & $past(alt_func_mask_in)) == 6'h00)
      else $error("Alternate function pin read non-zero.");

   dir_pin3_one_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      dir_read_s |=> reg_rdata_out[INPUT_ONLY_IDX] == 1'b1)
      else $error("Input-only direction bit read as zero.");

   pin3_never_drives_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !port_pins_five_to_zero_oe_out[INPUT_ONLY_IDX])
      else $error("Input-only pin is driven.");

   dir_floats_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (port_pins_five_to_zero_oe_out & $past(dir_r)) == 6'h00)
      else $error("Pin driven while its direction bit is one.");

   reset_inputs_a: assert property (@(posedge sys_clk_in)
      $fell(reset_in) |-> dir_r == DIR_RESET && port_pins_five_to_zero_oe_out == 6'h00)
      else $error("Pins not all inputs after reset.");

   latch_holds_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      quiet_data_s |=> $stable(latch_r))
      else $error("Output latch changed without a port write.");

   rmw_uses_pins_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (reg_op_in == OP_BIT_SET) && sel_data && !dir_write |=>
      latch_r == ($past(port_view) | $past(bit_mask)))
      else $error("Bit set did not start from pin levels.");

   open_drain_low_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (port_pins_five_to_zero_out & $past(open_drain_mask_in)) == 6'h00)
      else $error("Open-drain pin driven high.");

   osc_override_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ext_osc_mode_in ##1 ext_osc_mode_in |-> (port_pins_five_to_zero_oe_out & OSC_PIN_MASK) == 6'h00)
      else $error("Oscillator pins driven by the port.");

   flag_sticky_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      mismatch |=> port_change_flag_out)
      else $error("Mismatch did not set the change flag.");

   ioc_gated_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !ioc_enable && !port_change_flag_out |=> !port_change_flag_out)
      else $error("Change flag set with detection disabled.");

   pullup_off_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ((pullup_on_out & port_pins_five_to_zero_oe_out) == 6'h00) &&
      ((pullup_on_out & ~SHARED_FEATURE_MASK) == 6'h00))
      else $error("Pull-up on an output or unshared pin.");

   write_reaches_pin_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      port_write_s |=> ##1 (port_pins_five_to_zero_out & ~$past(open_drain_mask_in)) ==
      ($past(reg_wdata_in[5:0], 2) & ~$past(open_drain_mask_in)))
      else $error("Port write did not reach the pin drive.");

   dir_write_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      dir_write_s |=> dir_r == ($past(reg_wdata_in[5:0]) | INPUT_ONLY_MASK))
      else $error("Direction write not stored with pin three set.");

   dir_readback_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      dir_read_s |=> reg_rdata_out == {UNIMPL_BITS, $past(dir_r) | INPUT_ONLY_MASK})
      else $error("Direction read does not return the register.");

   rdata_holds_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      reg_op_in != OP_READ |=> $stable(reg_rdata_out))
      else $error("Read data changed without a read.");

   last_read_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      port_access |=> last_read_r == $past(pin_sync))
      else $error("Port access did not capture the pins.");

   flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      change_flag_clear_in && !mismatch |=> !port_change_flag_out)
      else $error("Change flag not cleared without a mismatch.");

   outputs_excluded_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !ioc_enable || ((pin_sync ^ last_read_r) & SHARED_FEATURE_MASK & dir_view) == 6'h00 |=>
      port_change_flag_out == $past(port_change_flag_out & ~change_flag_clear_in))
      else $error("Change flag set without a watched input mismatch.");

   analog_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      port_read_s |=> (reg_rdata_out[5:0] & $past(analog_mask_in)) == 6'h00)
      else $error("Analog pin read non-zero.");

   alt_no_drive_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (port_pins_five_to_zero_oe_out & $past(alt_func_mask_in)) == 6'h00)
      else $error("Alternate function pin driven by the port.");

   reset_pullups_a: assert property (@(posedge sys_clk_in)
      $fell(reset_in) |-> pullup_on_out == 6'h00 && !port_change_flag_out)
      else $error("Pull-ups or change flag active after reset.");

endmodule : sbp_port

//--- sbp_sync.sv
// Two-flop synchroniser for the port pin levels.
// Assumes the pins are asynchronous to sys_clk_in.
`timescale 1ns/100ps
module sbp_sync #(
   parameter int WIDTH = 6
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : sbp_sync

//--- testbench.sv
// Self-checking bench for the six-pin port with a model of the pin circuitry.
// Assumes one 40 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module testbench;
   import sbp_pkg::*;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   sbp_op_t op = OP_IDLE;
   logic sel = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [2:0] bidx = 3'h0;
   logic [7:0] intctl = 8'h00;
   logic [5:0] alt = 6'h00, ana = 6'h00, od = 6'h00, ext_en = 6'h00, ext_val = 6'h00;
   logic osc = 1'b0, pu_en = 1'b0, clr = 1'b0;
   logic flag;
   logic [5:0] pins, pout, poe, pup;
   logic [7:0] rdata, rd;
   int failures = 0;
   int tests_run = 0;
   always #12.5 sys_clk_in = ~sys_clk_in;
   sbp_port sbp_port_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_op_in(op),
      .reg_sel_in(sel), .reg_wdata_in(wdata), .reg_bit_in(bidx), .reg_rdata_out(rdata),
      .alt_func_mask_in(alt), .ext_osc_mode_in(osc), .analog_mask_in(ana),
      .open_drain_mask_in(od), .pullup_enable_in(pu_en), .interrupt_control_reg_in(intctl),
      .change_flag_clear_in(clr), .port_change_flag_out(flag),
      .port_pins_five_to_zero_in(pins), .port_pins_five_to_zero_out(pout),
      .port_pins_five_to_zero_oe_out(poe), .pullup_on_out(pup));
   sbp_pins_model sbp_pins_model_i (.sys_clk_in(sys_clk_in), .oe_in(poe), .drive_in(pout),
      .pullup_in(pup), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pins));
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : step
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Each access is followed by one idle cycle so op never changes twice at once.
   task automatic access(input sbp_op_t o, input logic s, input logic [7:0] w,
      input logic [2:0] b);
      op = o;
      sel = s;
      wdata = w;
      bidx = b;
      step(1);
      op = OP_IDLE;
      step(1);
   endtask : access
   task automatic read_reg(input logic s, output logic [7:0] d);
      access(OP_READ, s, 8'h00, 3'h0);
      d = rdata;
   endtask : read_reg
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_flag(input logic want);
      int n;
      n = 0;
      while (flag !== want && n < 8) begin
         step(1);
         n++;
      end
      if (flag !== want) begin
         failures++;
         $display("unexpected change flag wait: expected %b seen %b", want, flag);
         give_verdict();
      end
   endtask : wait_flag
   task automatic t_reset;
      check("oe", {2'h0, poe}, 8'h00);
      check("pullup", {2'h0, pup}, 8'h00);
      read_reg(SEL_PORT_PIN_DIRECTION, rd);
      check("dir", rd, 8'h3F);
      ext_en = 6'h3F;
      ext_val = 6'h2A;
      step(3);
      read_reg(SEL_PORT_PIN_DATA, rd);
      check("pins", rd, 8'h2A);
      $display("reset test done");
   endtask : t_reset
   task automatic t_drive;
      ext_en = 6'h08;
      ext_val = 6'h00;
      access(OP_WRITE, SEL_PORT_PIN_DATA, 8'hFF, 3'h0);
      access(OP_WRITE, SEL_PORT_PIN_DIRECTION, 8'h00, 3'h0);
      read_reg(SEL_PORT_PIN_DIRECTION, rd);
      check("dir", rd, 8'h08);
      check("oe", {2'h0, poe}, 8'h37);
      check("out", {2'h0, pout}, 8'h3F);
      step(2);
      read_reg(SEL_PORT_PIN_DATA, rd);
      check("pins", rd, 8'h37);
      step(20);
      check("held out", {2'h0, pout}, 8'h3F);
      $display("drive test done");
   endtask : t_drive
   task automatic t_rmw;
      od = 6'h01;
      ext_en = 6'h09;
      step(4);
      check("od oe", {2'h0, poe}, 8'h36);
      read_reg(SEL_PORT_PIN_DATA, rd);
      check("pins", rd, 8'h36);
      access(OP_BIT_CLR, SEL_PORT_PIN_DATA, 8'h00, 3'h5);
      step(2);
      check("rmw out", {2'h0, pout}, 8'h16);
      // Pin three reads low from outside, so its latch bit comes only from the set.
      access(OP_BIT_SET, SEL_PORT_PIN_DATA, 8'h00, 3'h3);
      check("rmw set", {2'h0, pout}, 8'h1E);
      od = 6'h00;
      $display("rmw test done");
   endtask : t_rmw
   task automatic t_override;
      alt = 6'h02;
      osc = 1'b1;
      ana = 6'h04;
      ext_en = 6'h08;
      ext_val = 6'h08;
      step(4);
      check("ovr oe", {2'h0, poe}, 8'h05);
      read_reg(SEL_PORT_PIN_DATA, rd);
      check("ovr pins", rd, 8'h08);
      alt = 6'h00;
      osc = 1'b0;
      ana = 6'h00;
      $display("override test done");
   endtask : t_override
   task automatic t_change;
      ext_en = 6'h00;
      pu_en = 1'b1;
      access(OP_WRITE, SEL_PORT_PIN_DIRECTION, 8'h3E, 3'h0);
      check("pullup out", {2'h0, pup}, 8'h0A);
      access(OP_WRITE, SEL_PORT_PIN_DIRECTION, 8'h3F, 3'h0);
      check("pullup", {2'h0, pup}, 8'h0B);
      step(3);
      read_reg(SEL_PORT_PIN_DATA, rd);
      ext_en = 6'h01;
      step(6);
      check("flag off", {7'h00, flag}, 8'h00);
      intctl = 8'h08;
      wait_flag(1'b1);
      clr = 1'b1;
      step(2);
      check("flag kept", {7'h00, flag}, 8'h01);
      read_reg(SEL_PORT_PIN_DATA, rd);
      step(1);
      check("flag clear", {7'h00, flag}, 8'h00);
      clr = 1'b0;
      $display("change test done");
   endtask : t_change
   initial begin
      step(3);
      reset_in = 1'b0;
      t_reset();
      t_drive();
      t_rmw();
      t_override();
      t_change();
      give_verdict();
   end
endmodule : testbench
